//--- include/ocp_seq_pkg.sv
/*
 * Constants and state encoding for the overcurrent window and retry
 * sequencer. Assumes a 100 MHz ref_clk and an external switching clock
 * strobe, one pulse per switching cycle.
 */
package ocp_seq_pkg;
  // clock and quantisation of the on-time
  localparam int CLK_PERIOD_NS = 10;
  localparam int QUANTUM_NS = 10;
  localparam int QUANTUM_CYCLES = (QUANTUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QT_W = 4;
  // on-time counter width, in quanta
  localparam int ON_W = 8;
  localparam logic [ON_W-1:0] ON_MAX = 8'hff;
  // window is 3/4 of the prior on-time
  localparam int WINDOW_NUM = 3;
  localparam int WINDOW_SHIFT = 2;
  // trip setting code
  localparam int TRIP_W = 6;
  localparam logic [TRIP_W-1:0] TRIP_RST = 6'h00;
  // soft-start: 32 steps, 64 switching cycles each
  localparam int LEVEL_W = 6;
  localparam int STEP_W = 6;
  localparam logic [LEVEL_W-1:0] SS_STEPS = 6'h20;
  localparam int SS_STEP_CYCLES = 32'h40;
  localparam logic [STEP_W-1:0] SS_STEP_LAST = STEP_W'(SS_STEP_CYCLES - 1);
  // retry wait: four soft-start durations, in switching cycles
  localparam int WAIT_W = 14;
  localparam int RETRY_SS_PERIODS = 4;
  localparam logic [WAIT_W-1:0] RETRY_WAIT_CYCLES = WAIT_W'(RETRY_SS_PERIODS * int'(SS_STEPS) * SS_STEP_CYCLES);
  // sequencer states
  typedef enum logic [2:0] {
    ST_CAPTURE,
    ST_SOFT,
    ST_RUN,
    ST_FINISH,
    ST_HALF,
    ST_WAIT
  } seq_state_e;
endpackage : ocp_seq_pkg

//--- rtl/on_time_meter.sv
/*
 * Measures high-side on-time in fixed quanta and opens the sense window
 * for up to 3/4 of the previous cycle's on-time. Assumes highOn is the
 * registered high-side gate drive of the same clock domain.
 */
`timescale 1ns/100ps
module on_time_meter (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // gate state
  input wire logic highOn,
  // measurement
  output logic [ocp_seq_pkg::ON_W-1:0] windowLen,
  output logic [ocp_seq_pkg::ON_W-1:0] halfLen,
  output logic windowOpen
);
  import ocp_seq_pkg::*;

  logic [QT_W-1:0] qtFf, nxt_qt;
  logic [ON_W-1:0] onCountFf, nxt_onCount;
  logic [ON_W-1:0] prevOnFf, nxt_prevOn;
  logic lastHighFf, nxt_lastHigh;
  logic [ON_W+1:0] scaled;

  ////////////////////////////////////////////////////////////////////////
  // quantum ticks and on-time count, latched at the high-side fall
  always_comb begin
    nxt_prevOn = prevOnFf;
    nxt_lastHigh = highOn;
    // a rising edge restarts the count, and its own clock counts too
    if (highOn && !lastHighFf) begin
      nxt_qt = '0;
      nxt_onCount = '0;
    end else begin
      nxt_qt = qtFf;
      nxt_onCount = onCountFf;
    end
    if (highOn) begin
      if (nxt_qt == QT_W'(QUANTUM_CYCLES - 1)) begin
        nxt_qt = '0;
        if (nxt_onCount != ON_MAX) begin
          nxt_onCount = nxt_onCount + 1'b1; // saturates
        end
      end else begin
        nxt_qt = nxt_qt + 1'b1;
      end
    end
    if (lastHighFf && !highOn) begin
      nxt_prevOn = onCountFf;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      qtFf <= '0;
      onCountFf <= '0;
      prevOnFf <= '0;
      lastHighFf <= 1'b0;
    end else if (clkEn) begin
      qtFf <= nxt_qt;
      onCountFf <= nxt_onCount;
      prevOnFf <= nxt_prevOn;
      lastHighFf <= nxt_lastHigh;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // window and half lengths from the prior on-time
  always_comb begin
    scaled = ({2'b00, prevOnFf} * (ON_W+2)'(WINDOW_NUM)) >> WINDOW_SHIFT;
    windowLen = scaled[ON_W-1:0];
    halfLen = prevOnFf >> 1;
    windowOpen = highOn && lastHighFf && (onCountFf < windowLen);
  end

  chk_prev_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && lastHighFf && !highOn) |=> prevOnFf == $past(onCountFf)) else $error("on-time not latched");
  chk_window_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    windowOpen |-> (highOn && onCountFf < ((prevOnFf * 3) >> 2))) else $error("window past 3/4");
endmodule : on_time_meter

//--- rtl/overcurrent_window_retry_sequencer.sv
/*
 * Overcurrent sense window, soft-start stepping and shutdown-retry
 * sequencing for a synchronous buck controller. Assumes cycleStart pulses
 * once per switching cycle, pwmHighReq comes from the PWM latch, and
 * tripCodeValid strobes once the trip setting conversion is done.
 */
`timescale 1ns/100ps
// What this block does
// - sense only within first 3/4 on-time
// - window from prior on-time, 10 ns quanta
// - comparator high inside window means fault in soft-start or run
// - soft-start doubles trip reference, then normal
// - on fault finish cycle, then half pulse
// - gates off, wait four soft-starts, retry
// - soft-start: 32 steps of 64 cycles
// - capture six-bit trip code before soft-start
module overcurrent_window_retry_sequencer #(
  parameter logic [ocp_seq_pkg::WAIT_W-1:0] RETRY_WAIT_CYCLES = ocp_seq_pkg::RETRY_WAIT_CYCLES
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // switching timing
  input wire logic cycleStart,
  input wire logic pwmHighReq,
  // current sense
  input wire logic overcurrentComparator,
  input wire logic [ocp_seq_pkg::TRIP_W-1:0] tripCode,
  input wire logic tripCodeValid,
  // gate drivers
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  // reference and status
  output logic [ocp_seq_pkg::TRIP_W:0] limitReference,
  output logic [ocp_seq_pkg::LEVEL_W-1:0] softRefLevel,
  output logic softStartActive,
  output logic overcurrentFault
);
  import ocp_seq_pkg::*;

  seq_state_e stateFf, nxt_state;
  logic [TRIP_W-1:0] tripHeldFf, nxt_tripHeld;
  logic [LEVEL_W-1:0] levelFf, nxt_level;
  logic [STEP_W-1:0] stepCycFf, nxt_stepCyc;
  logic [WAIT_W-1:0] waitCntFf, nxt_waitCnt;
  logic [ON_W-1:0] halfCntFf, nxt_halfCnt;
  logic hsFf, nxt_hs;
  logic lsFf, nxt_ls;
  logic [TRIP_W:0] refFf, nxt_ref;
  logic faultFf, nxt_fault;
  logic softFf, nxt_soft;
  logic windowOpen;
  logic [ON_W-1:0] windowLen;
  logic [ON_W-1:0] halfLen;
  logic trip;

  // states in which the gates follow the PWM latch
  function automatic logic follows_pwm(input seq_state_e s);
    follows_pwm = (s == ST_SOFT) || (s == ST_RUN) || (s == ST_FINISH);
  endfunction : follows_pwm

  // states in which a trip is acted on
  function automatic logic senses(input seq_state_e s);
    senses = (s == ST_SOFT) || (s == ST_RUN);
  endfunction : senses

  ////////////////////////////////////////////////////////////////////////
  // on-time measurement and sense window
  on_time_meter u_meter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .highOn(hsFf),
    .windowLen(windowLen),
    .halfLen(halfLen),
    .windowOpen(windowOpen)
  );

  // comparator ignored outside the window
  assign trip = senses(stateFf) && windowOpen && overcurrentComparator;

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state and counters
  always_comb begin
    nxt_state = stateFf;
    nxt_tripHeld = tripHeldFf;
    nxt_level = levelFf;
    nxt_stepCyc = stepCycFf;
    nxt_waitCnt = waitCntFf;
    nxt_halfCnt = halfCntFf;
    unique case (stateFf)
      ST_CAPTURE: begin
        if (tripCodeValid) begin
          nxt_tripHeld = tripCode;
          nxt_state = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (trip) begin
          nxt_state = ST_FINISH;
        end else if (cycleStart) begin
          if (stepCycFf == SS_STEP_LAST) begin
            nxt_stepCyc = '0;
            nxt_level = levelFf + 1'b1;
            if (levelFf == SS_STEPS - 1'b1) begin
              nxt_state = ST_RUN;
            end
          end else begin
            nxt_stepCyc = stepCycFf + 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (trip) begin
          nxt_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (cycleStart) begin
          nxt_halfCnt = '0;
          nxt_state = ST_HALF;
        end
      end
      ST_HALF: begin
        if (halfCntFf >= halfLen) begin
          nxt_waitCnt = '0;
          nxt_state = ST_WAIT;
        end else begin
          nxt_halfCnt = halfCntFf + 1'b1;
        end
      end
      ST_WAIT: begin
        if (cycleStart) begin
          if (waitCntFf == RETRY_WAIT_CYCLES - 1'b1) begin
            nxt_level = '0;
            nxt_stepCyc = '0;
            nxt_state = ST_SOFT;
          end else begin
            nxt_waitCnt = waitCntFf + 1'b1;
          end
        end
      end
      default: begin
        nxt_state = ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateFf <= ST_CAPTURE;
      tripHeldFf <= TRIP_RST;
      levelFf <= '0;
      stepCycFf <= '0;
      waitCntFf <= '0;
      halfCntFf <= '0;
    end else if (clkEn) begin
      stateFf <= nxt_state;
      tripHeldFf <= nxt_tripHeld;
      levelFf <= nxt_level;
      stepCycFf <= nxt_stepCyc;
      waitCntFf <= nxt_waitCnt;
      halfCntFf <= nxt_halfCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs: gates, reference, fault pulse
  always_comb begin
    nxt_hs = 1'b0;
    nxt_ls = 1'b0;
    // the cycle start that closes the finish cycle opens the half pulse instead
    if (follows_pwm(stateFf) && !(stateFf == ST_FINISH && cycleStart)) begin
      nxt_hs = pwmHighReq;
      nxt_ls = !pwmHighReq;
    end else if (stateFf == ST_HALF) begin
      nxt_hs = halfCntFf < halfLen;
    end
    if (stateFf == ST_SOFT) begin
      nxt_ref = {tripHeldFf, 1'b0};
    end else begin
      nxt_ref = {1'b0, tripHeldFf};
    end
    nxt_fault = trip;
    nxt_soft = (nxt_state == ST_SOFT);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hsFf <= 1'b0;
      lsFf <= 1'b0;
      refFf <= '0;
      faultFf <= 1'b0;
      softFf <= 1'b0;
    end else if (clkEn) begin
      hsFf <= nxt_hs;
      lsFf <= nxt_ls;
      refFf <= nxt_ref;
      faultFf <= nxt_fault;
      softFf <= nxt_soft;
    end
  end

  assign high_side_gate_drive = hsFf;
  assign low_side_gate_drive = lsFf;
  assign limitReference = refFf;
  assign softRefLevel = levelFf;
  assign softStartActive = softFf;
  assign overcurrentFault = faultFf;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_trip_in_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && senses(stateFf) && windowOpen && overcurrentComparator) |=> overcurrentFault) else $error("trip missed");
  chk_no_trip_outside: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && !windowOpen) |=> !overcurrentFault) else $error("trip outside window");
  chk_fault_finish: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && trip) |=> stateFf == ST_FINISH) else $error("fault not sequenced");
  chk_half_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && stateFf == ST_HALF && halfCntFf >= halfLen) |=> stateFf == ST_WAIT) else $error("half pulse overrun");
  chk_wait_gates_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && stateFf == ST_WAIT) |=> (!high_side_gate_drive && !low_side_gate_drive)) else $error("gate on in wait");
  chk_ss_double_ref: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && stateFf == ST_SOFT) |=> limitReference == {$past(tripHeldFf), 1'b0}) else $error("soft-start ref");
  chk_run_normal_ref: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && stateFf == ST_RUN) |=> limitReference == {1'b0, $past(tripHeldFf)}) else $error("run ref");
  chk_step_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && stateFf == ST_SOFT && !trip && cycleStart && stepCycFf == SS_STEP_LAST)
    |=> (levelFf == $past(levelFf) + 6'h01 && stepCycFf == 6'h00)) else $error("step advance");
  chk_retry_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && stateFf == ST_WAIT && cycleStart && waitCntFf == RETRY_WAIT_CYCLES - 1'b1)
    |=> (stateFf == ST_SOFT && levelFf == 6'h00 && stepCycFf == 6'h00)) else $error("retry restart");
endmodule : overcurrent_window_retry_sequencer

//--- test/overcurrent_window_retry_sequencer_tb.sv
/*
 * Self-checking bench for the overcurrent window and retry sequencer.
 * Assumes a 24-clock switching period made by the bench and a retry wait
 * shortened to four switching cycles; soft-start keeps its full length.
 */
`timescale 1ns/100ps
module overcurrent_window_retry_sequencer_tb;
  import ocp_seq_pkg::*;
  localparam int PERIOD = 24;
  localparam logic [WAIT_W-1:0] WAIT_SIM = 14'h0004;
  localparam logic [TRIP_W-1:0] CODE = 6'h2d;
  logic ref_clk, rst_n, clkEn, cycleStart, pwmHighReq, overcurrentComparator, tripCodeValid;
  logic [TRIP_W-1:0] tripCode;
  logic hsDrive, lsDrive, softStartActive, overcurrentFault;
  logic [TRIP_W:0] limitReference;
  logic [LEVEL_W-1:0] softRefLevel;
  int mismatches, n_compared, hsCnt, lsCnt, faultCnt, offCnt;

  ////////////////////////////////////////////////////////////////////////////
  // design under test
  overcurrent_window_retry_sequencer #(.RETRY_WAIT_CYCLES(WAIT_SIM)) u_overcurrent_window_retry_sequencer (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .cycleStart(cycleStart), .pwmHighReq(pwmHighReq),
    .overcurrentComparator(overcurrentComparator), .tripCode(tripCode), .tripCodeValid(tripCodeValid),
    .high_side_gate_drive(hsDrive), .low_side_gate_drive(lsDrive),
    .limitReference(limitReference), .softRefLevel(softRefLevel),
    .softStartActive(softStartActive), .overcurrentFault(overcurrentFault)
  );

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string what, input logic [15:0] expVal, input logic [15:0] gotVal);
    n_compared++;
    if (gotVal !== expVal) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, expVal, gotVal);
    end
  endtask : check

  // verdict and end of run
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // one switching cycle: on-time in clocks, comparator pulse index (-1 none)
  task automatic sw_cycle(input int onClks, input int cmpAt);
    hsCnt = 0;
    lsCnt = 0;
    faultCnt = 0;
    for (int i = 0; i < PERIOD; i++) begin
      @(posedge ref_clk);
      cycleStart <= (i == 0);
      pwmHighReq <= (i < onClks);
      overcurrentComparator <= (i == cmpAt);
      @(negedge ref_clk);
      hsCnt += int'(hsDrive === 1'b1);
      lsCnt += int'(lsDrive === 1'b1);
      faultCnt += int'(overcurrentFault === 1'b1);
    end
  endtask : sw_cycle

  ////////////////////////////////////////////////////////////////////////////
  // idle after reset, then trip code capture
  task automatic test_capture();
    @(negedge ref_clk);
    check("idle outputs", 16'h0000, 16'({hsDrive, lsDrive, softStartActive, overcurrentFault, limitReference}));
    sw_cycle(8, -1);
    check("no start before capture", 16'h0000, 16'(softStartActive));
    @(posedge ref_clk);
    tripCodeValid <= 1'b1;
    tripCode <= CODE;
    @(posedge ref_clk);
    tripCodeValid <= 1'b0;
    tripCode <= 6'h12;
    repeat (2) @(negedge ref_clk);
    check("soft-start entered", 16'h0001, 16'(softStartActive));
    check("doubled reference", 16'({CODE, 1'b0}), 16'(limitReference));
  endtask : test_capture

  // 32 steps of 64 switching cycles, then normal reference
  task automatic test_soft_start();
    repeat (63) sw_cycle(8, -1);
    check("level before step", 16'h0000, 16'(softRefLevel));
    sw_cycle(8, -1);
    check("level after step", 16'h0001, 16'(softRefLevel));
    repeat (1983) sw_cycle(8, -1);
    check("still soft", 16'h0001, 16'(softStartActive));
    check("level 31", 16'h001f, 16'(softRefLevel));
    sw_cycle(8, -1);
    check("soft done", 16'h0000, 16'(softStartActive));
    check("final level", 16'h0020, 16'(softRefLevel));
    check("normal reference", 16'({1'b0, CODE}), 16'(limitReference));
  endtask : test_soft_start

  // window from the prior on-time, ends at three quarters
  task automatic test_window();
    sw_cycle(4, -1);
    sw_cycle(16, 8);
    check("short prior window", 16'h0000, 16'(faultCnt));
    sw_cycle(16, 15);
    check("late comparator", 16'h0000, 16'(faultCnt));
  endtask : test_window

  // trip, half pulse, wait, retry from zero
  task automatic test_trip();
    sw_cycle(16, 3);
    check("trip in window", 16'h0001, 16'(faultCnt));
    check("cycle finished", 16'h0010, 16'(hsCnt));
    sw_cycle(16, 3);
    check("half pulse", 16'h0008, 16'(hsCnt));
    offCnt = 0;
    repeat (3) begin
      sw_cycle(16, 3);
      offCnt += hsCnt + lsCnt + faultCnt;
    end
    check("gates off in wait", 16'h0000, 16'(offCnt));
    sw_cycle(16, -1);
    check("retry after four waits", 16'h0001, 16'(softStartActive));
    sw_cycle(16, -1);
    check("retry soft-start", 16'h0001, 16'(softStartActive));
    check("retry level zero", 16'h0000, 16'(softRefLevel));
    check("retry doubled", 16'({CODE, 1'b0}), 16'(limitReference));
    repeat (61) sw_cycle(8, -1);
    check("step counter restarted", 16'h0000, 16'(softRefLevel));
    repeat (4) sw_cycle(8, -1);
    check("first retry step", 16'h0001, 16'(softRefLevel));
  endtask : test_trip

  // trip inside soft-start, retry drops the part-done step
  task automatic test_soft_trip();
    sw_cycle(8, 3);
    check("soft-start trip", 16'h0001, 16'(faultCnt));
    sw_cycle(8, -1);
    check("half of short pulse", 16'h0004, 16'(hsCnt));
    repeat (4) sw_cycle(8, -1);
    check("soft retry level zero", 16'h0000, 16'(softRefLevel));
    repeat (63) sw_cycle(8, -1);
    check("part step not kept", 16'h0000, 16'(softRefLevel));
    sw_cycle(8, -1);
    check("full step after retry", 16'h0001, 16'(softRefLevel));
  endtask : test_soft_trip

  // clock enable low holds both gate drives
  task automatic test_freeze();
    @(posedge ref_clk);
    clkEn <= 1'b0;
    sw_cycle(8, -1);
    check("frozen high side", 16'h0000, 16'(hsCnt));
    check("frozen low side", 16'h0018, 16'(lsCnt));
    @(posedge ref_clk);
    clkEn <= 1'b1;
  endtask : test_freeze

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    cycleStart = 1'b0;
    pwmHighReq = 1'b0;
    overcurrentComparator = 1'b0;
    tripCodeValid = 1'b0;
    tripCode = 6'h00;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_capture();
    test_soft_start();
    test_window();
    test_trip();
    test_soft_trip();
    test_freeze();
    end_of_test();
  end

  // hang guard, about 1.7 times the expected run of some 53000 clocks
  initial begin
    #900000;
    mismatches++;
    end_of_test();
  end
endmodule : overcurrent_window_retry_sequencer_tb
